/* File: common/mies_pkg.sv */
// Overview of operation
// - immediate minus accumulator sets Z, DC, C
// - carry is inverted borrow on subtract
// - table address {pointer bit0, accumulator}, low byte
// - word bits 13..8 go to table high
// - accumulator copied into timer0 mode register
// - timer0 mode register copied into accumulator
// - xor with file, Z, d picks target
// - xor with immediate into accumulator, Z
package mies_pkg;
   // operation codes presented by the instruction decoder
   typedef enum logic [2:0] {
      MIES_OP_NONE    = 3'h0,
      MIES_OP_SUBIMM  = 3'h1,
      MIES_OP_TABLE   = 3'h2,
      MIES_OP_TMDLOAD = 3'h3,
      MIES_OP_TMDREAD = 3'h4,
      MIES_OP_XORFILE = 3'h5,
      MIES_OP_XORIMM  = 3'h6
   } mies_op_t;
   // table read sequencer states
   typedef enum logic [0:0] {
      MIES_ST_IDLE  = 1'h0,
      MIES_ST_FETCH = 1'h1
   } mies_state_t;
   localparam int          MIES_DATA_W   = 8;
   localparam int          MIES_ROM_W    = 14;
   localparam int          MIES_ADDR_W   = 9;
   localparam int          MIES_TABLE_DATA_HIGH_W   = 6;
   localparam int          MIES_NIB      = 4;
   localparam logic [7:0]  MIES_ACC_RST  = 8'h00;
   localparam logic [7:0]  MIES_TMD_RST  = 8'hff;
   localparam logic [5:0]  MIES_TABLE_DATA_HIGH_RST = 6'h00;
endpackage

/* File: src/mies_sub_unit.sv */
`timescale 1ns/10ps
// subtracter: minuend minus subtrahend with borrow-style flags
module mies_sub_unit (
   input  wire logic [7:0] minuend,
   input  wire logic [7:0] subtrahend,
   output logic      [7:0] diff,
   output logic            carry,
   output logic            halfCarry
);
   logic [8:0] full;  // nine bits, top bit is the borrow
   logic [4:0] low;   // low nibble with borrow
   always_comb begin
      full      = {1'b0, minuend} - {1'b0, subtrahend};
      low       = {1'b0, minuend[3:0]} - {1'b0, subtrahend[3:0]};
      diff      = full[7:0];
      carry     = ~full[8];   // set when no borrow
      halfCarry = ~low[4];    // nibble borrow inverted likewise
   end
endmodule

/* File: src/mies_exec.sv */
`timescale 1ns/10ps
// execution unit for the subtract, xor, timer-mode and table-read subset
module mies_exec (
   input  wire logic                clk_sys,
   input  wire logic                rst,
   input  wire logic                opValid,       // decoder presents an instruction
   input  wire mies_pkg::mies_op_t  opCode,        // which instruction
   input  wire logic [7:0]          immediate,     // immediate operand
   input  wire logic                destFile,      // 0 accumulator, 1 file register
   input  wire logic [7:0]          fileData,      // read data of the addressed file
   input  wire logic [7:0]          tablePointerHigh, // pointer register, bit 0 used
   input  wire logic [13:0]         romData,       // program rom word, one cycle late
   output logic      [7:0]          accumulator,
   output logic      [7:0]          timer0ModeReg,
   output logic      [5:0]          tableDataHigh,
   output logic                     zeroFlag,
   output logic                     halfCarryFlag,
   output logic                     carryFlag,
   output logic                     fileWrite,     // pulse: write fileWrData
   output logic      [7:0]          fileWrData,
   output logic      [8:0]          romAddr,
   output logic                     busy,          // high in second table cycle
   output logic                     done           // pulse: instruction retired
);
   mies_pkg::mies_state_t state;       // table read sequencer
   logic [7:0]            subDiff;     // immediate minus accumulator
   logic                  subCarry;    // inverted borrow
   logic                  subHalf;     // inverted nibble borrow
   logic [7:0]            xorFile;     // accumulator xor file
   logic [7:0]            xorImm;      // accumulator xor immediate
   logic                  accept;      // new instruction taken

   // one shared subtracter; immediate is the minuend
   mies_sub_unit uSub (
      .minuend    (immediate),
      .subtrahend (accumulator),
      .diff       (subDiff),
      .carry      (subCarry),
      .halfCarry  (subHalf)
   );

   // new work is taken only while no table read is in flight
   always_comb begin
      accept  = opValid && (state == mies_pkg::MIES_ST_IDLE);
      xorFile = accumulator ^ fileData;
      xorImm  = accumulator ^ immediate;
   end

   // table sequencer: address cycle then data cycle
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state <= mies_pkg::MIES_ST_IDLE;
      end else begin
         unique case (state)
            mies_pkg::MIES_ST_IDLE: begin
               if (accept && opCode == mies_pkg::MIES_OP_TABLE) begin
                  state <= mies_pkg::MIES_ST_FETCH;
               end
            end
            mies_pkg::MIES_ST_FETCH: begin
               state <= mies_pkg::MIES_ST_IDLE;
            end
         endcase
      end
   end

   // rom address registered so rom sees it for a full cycle
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         romAddr <= '0;
         busy    <= 1'b0;
      end else begin
         if (accept && opCode == mies_pkg::MIES_OP_TABLE) begin
            romAddr <= {tablePointerHigh[0], accumulator};
            busy    <= 1'b1;
         end else begin
            busy    <= 1'b0;
         end
      end
   end

   // accumulator update
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         accumulator <= mies_pkg::MIES_ACC_RST;
      end else if (state == mies_pkg::MIES_ST_FETCH) begin
         accumulator <= romData[7:0];
      end else if (accept) begin
         unique case (opCode)
            mies_pkg::MIES_OP_SUBIMM:  accumulator <= subDiff;
            mies_pkg::MIES_OP_TMDREAD: accumulator <= timer0ModeReg;
            mies_pkg::MIES_OP_XORFILE: begin
               if (!destFile) begin
                  accumulator <= xorFile;
               end
            end
            mies_pkg::MIES_OP_XORIMM:  accumulator <= xorImm;
            default: ; // table, load and none leave it alone
         endcase
      end
   end

   // timer0 mode register
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         timer0ModeReg <= mies_pkg::MIES_TMD_RST;
      end else if (accept && opCode == mies_pkg::MIES_OP_TMDLOAD) begin
         timer0ModeReg <= accumulator;
      end
   end

   // table high data
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         tableDataHigh <= mies_pkg::MIES_TABLE_DATA_HIGH_RST;
      end else if (state == mies_pkg::MIES_ST_FETCH) begin
         tableDataHigh <= romData[13:8];
      end
   end

   // status flags
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         zeroFlag      <= 1'b0;
         halfCarryFlag <= 1'b0;
         carryFlag     <= 1'b0;
      end else if (accept) begin
         if (opCode == mies_pkg::MIES_OP_SUBIMM) begin
            zeroFlag      <= (subDiff == 8'h00);
            halfCarryFlag <= subHalf;
            carryFlag     <= subCarry;
         end else if (opCode == mies_pkg::MIES_OP_XORFILE) begin
            zeroFlag      <= (xorFile == 8'h00);
         end else if (opCode == mies_pkg::MIES_OP_XORIMM) begin
            zeroFlag      <= (xorImm == 8'h00);
         end
      end
   end

   // file write-back and retire pulse
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         fileWrite  <= 1'b0;
         fileWrData <= 8'h00;
         done       <= 1'b0;
      end else begin
         fileWrite  <= accept && opCode == mies_pkg::MIES_OP_XORFILE && destFile;
         fileWrData <= xorFile;
         done       <= (state == mies_pkg::MIES_ST_FETCH) ||
                       (accept && opCode != mies_pkg::MIES_OP_TABLE
                        && opCode != mies_pkg::MIES_OP_NONE);
      end
   end

   // checks
   property p_sub_res;
      @(posedge clk_sys) disable iff (rst)
      accept && opCode == mies_pkg::MIES_OP_SUBIMM |=>
      accumulator == $past(immediate) - $past(accumulator);
   endproperty
   a_sub_res: assert property (p_sub_res) else $error("subtract result wrong");
   // half carry is an inverted nibble borrow; zero follows the difference
   property p_sub_dc;
      @(posedge clk_sys) disable iff (rst)
      accept && opCode == mies_pkg::MIES_OP_SUBIMM |=>
      halfCarryFlag == ($past(immediate[3:0]) >= $past(accumulator[3:0]))
      && zeroFlag == ($past(immediate) == $past(accumulator));
   endproperty
   a_sub_dc: assert property (p_sub_dc) else $error("subtract flags wrong");
   // xor into the accumulator must not also write the file back
   property p_xor_a;
      @(posedge clk_sys) disable iff (rst)
      accept && opCode == mies_pkg::MIES_OP_XORFILE && !destFile |=>
      accumulator == ($past(accumulator) ^ $past(fileData)) && !fileWrite
      && zeroFlag == (accumulator == 8'h00);
   endproperty
   a_xor_a: assert property (p_xor_a) else $error("xor file to accumulator wrong");
   property p_sub_c;
      @(posedge clk_sys) disable iff (rst)
      accept && opCode == mies_pkg::MIES_OP_SUBIMM |=>
      carryFlag == ($past(immediate) >= $past(accumulator));
   endproperty
   a_sub_c: assert property (p_sub_c) else $error("carry not inverted borrow");
   property p_tbl_lo;
      @(posedge clk_sys) disable iff (rst)
      accept && opCode == mies_pkg::MIES_OP_TABLE |=>
      romAddr == {$past(tablePointerHigh[0]), $past(accumulator)} ##1
      accumulator == $past(romData[7:0]);
   endproperty
   a_tbl_lo: assert property (p_tbl_lo) else $error("table low byte wrong");
   property p_tbl_hi;
      @(posedge clk_sys) disable iff (rst)
      accept && opCode == mies_pkg::MIES_OP_TABLE |-> ##2 tableDataHigh == $past(romData[13:8]);
   endproperty
   a_tbl_hi: assert property (p_tbl_hi) else $error("table high wrong");
   property p_tmd_ld;
      @(posedge clk_sys) disable iff (rst)
      accept && opCode == mies_pkg::MIES_OP_TMDLOAD |=>
      timer0ModeReg == $past(accumulator) && $stable(accumulator);
   endproperty
   a_tmd_ld: assert property (p_tmd_ld) else $error("mode load wrong");
   property p_tmd_rd;
      @(posedge clk_sys) disable iff (rst)
      accept && opCode == mies_pkg::MIES_OP_TMDREAD |=>
      accumulator == $past(timer0ModeReg) && $stable(timer0ModeReg) && done;
   endproperty
   a_tmd_rd: assert property (p_tmd_rd) else $error("mode read wrong");
   property p_xor_f;
      @(posedge clk_sys) disable iff (rst)
      accept && opCode == mies_pkg::MIES_OP_XORFILE && destFile |=>
      fileWrite && fileWrData == ($past(accumulator) ^ $past(fileData)) && $stable(accumulator);
   endproperty
   a_xor_f: assert property (p_xor_f) else $error("xor file write wrong");
   property p_xor_i;
      @(posedge clk_sys) disable iff (rst)
      accept && opCode == mies_pkg::MIES_OP_XORIMM |=>
      accumulator == ($past(accumulator) ^ $past(immediate)) && zeroFlag == (accumulator == 8'h00);
   endproperty
   a_xor_i: assert property (p_xor_i) else $error("xor immediate wrong");
   property p_tbl_two;
      @(posedge clk_sys) disable iff (rst)
      accept && opCode == mies_pkg::MIES_OP_TABLE |=> busy && !done ##1 done && !busy;
   endproperty
   a_tbl_two: assert property (p_tbl_two) else $error("table not two cycles");
   c_table: cover property (@(posedge clk_sys) accept && opCode == mies_pkg::MIES_OP_TABLE);
   c_borrow: cover property (@(posedge clk_sys) accept && opCode == mies_pkg::MIES_OP_SUBIMM
      && !subCarry);
   c_xorwb: cover property (@(posedge clk_sys) fileWrite);
   // an instruction offered while the table read holds the core
   c_refused: cover property (@(posedge clk_sys) opValid && busy);
endmodule

/* File: tb/tb.sv */
`timescale 1ns/10ps
// self-checking bench for the execution subset, driven on the falling edge
module tb;
   logic                clk_sys;          // instruction clock, 4 ns
   logic                rst;              // synchronous, active high
   logic                opValid;
   mies_pkg::mies_op_t  opCode;
   logic [7:0]          immediate;
   logic                destFile;
   logic [7:0]          fileData;
   logic [7:0]          tablePointerHigh;
   logic [13:0]         romData;
   logic [7:0]          accumulator;
   logic [7:0]          timer0ModeReg;
   logic [5:0]          tableDataHigh;
   logic                zeroFlag;
   logic                halfCarryFlag;
   logic                carryFlag;
   logic                fileWrite;
   logic [7:0]          fileWrData;
   logic [8:0]          romAddr;
   logic                busy;
   logic                done;
   int                  error_cnt;        // mismatches
   int                  cmp_count;        // comparisons made
   logic [7:0]          ea;               // bench copy of the accumulator
   mies_exec u_dut (.clk_sys(clk_sys), .rst(rst), .opValid(opValid), .opCode(opCode),
      .immediate(immediate), .destFile(destFile), .fileData(fileData),
      .tablePointerHigh(tablePointerHigh), .romData(romData), .accumulator(accumulator),
      .timer0ModeReg(timer0ModeReg), .tableDataHigh(tableDataHigh), .zeroFlag(zeroFlag),
      .halfCarryFlag(halfCarryFlag), .carryFlag(carryFlag), .fileWrite(fileWrite),
      .fileWrData(fileWrData), .romAddr(romAddr), .busy(busy), .done(done));
   // free-running clock
   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end
   // one comparison; case inequality, so an unknown bit matches only an unknown expected bit
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      cmp_count++;
      if (g !== e) begin
         error_cnt++;
         $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic end_of_test();
      $display("counts: %0d compared, %0d mismatched", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // present one single-cycle instruction; opValid is left up for back-to-back use
   task automatic op(input mies_pkg::mies_op_t c, input logic [7:0] i, input logic d,
                     input logic [7:0] f);
      opValid = 1'b1;
      opCode = c;
      immediate = i;
      destFile = d;
      fileData = f;
      @(negedge clk_sys);
      chk(done, 1'b1);
   endtask
   // subtract helper: carry means no borrow, half carry no borrow from the low nibble
   task automatic sub(input logic [7:0] i);
      logic [7:0] e;
      logic       c;
      logic       h;
      e = i - ea;
      c = (i >= ea);
      h = (i[3:0] >= ea[3:0]);
      op(mies_pkg::MIES_OP_SUBIMM, i, 1'b0, 8'h00);
      chk(accumulator, e);
      chk(carryFlag, c);
      chk(halfCarryFlag, h);
      chk(zeroFlag, e == 8'h00);
      ea = e;
   endtask
   // xor-immediate helper, also used to place a known accumulator value
   task automatic xr(input logic [7:0] i);
      op(mies_pkg::MIES_OP_XORIMM, i, 1'b0, 8'h00);
      ea = ea ^ i;
      chk(accumulator, ea);
      chk(zeroFlag, ea == 8'h00);
   endtask
   // table read: address out after one edge, word consumed after two
   task automatic tbl(input logic [7:0] p, input logic [13:0] w);
      opValid = 1'b1;
      opCode = mies_pkg::MIES_OP_TABLE;
      tablePointerHigh = p;
      @(negedge clk_sys);
      chk(busy, 1'b1);
      chk(done, 1'b0);
      chk(romAddr, {p[0], ea});
      romData = w;
      opCode = mies_pkg::MIES_OP_XORIMM; // held while busy, must be refused
      immediate = 8'hff;
      @(negedge clk_sys);
      chk(accumulator, w[7:0]);
      chk(tableDataHigh, w[13:8]);
      chk(done, 1'b1);
      chk(busy, 1'b0);
      ea = w[7:0];
      opValid = 1'b0;
      romData = ~w; // rom word no longer valid
      @(negedge clk_sys);
      chk(accumulator, ea);
      chk(done, 1'b0);
   endtask
   task automatic t_reset();
      chk(accumulator, mies_pkg::MIES_ACC_RST);
      chk(timer0ModeReg, mies_pkg::MIES_TMD_RST);
      chk(tableDataHigh, mies_pkg::MIES_TABLE_DATA_HIGH_RST);
      chk(romAddr, 9'h000);
      chk({zeroFlag, halfCarryFlag, carryFlag, fileWrite, busy, done}, 6'h00);
      $display("test reset done");
   endtask
   task automatic t_sub();
      xr(8'h06);
      sub(8'h05);
      sub(8'hff);
      sub(8'h10);
      sub(8'h00);
      $display("test subtract done");
   endtask
   task automatic t_xor();
      xr(ea ^ 8'hf0);
      op(mies_pkg::MIES_OP_XORFILE, 8'h00, 1'b1, 8'ha5);
      chk({fileWrite, fileWrData}, 9'h155);
      chk(accumulator, 8'hf0);
      chk(zeroFlag, 1'b0);
      op(mies_pkg::MIES_OP_XORFILE, 8'h00, 1'b0, 8'hf0);
      chk({fileWrite, accumulator, zeroFlag}, 10'h001);
      ea = 8'h00;
      $display("test xor done");
   endtask
   task automatic t_tmd();
      xr(ea ^ 8'haa);
      op(mies_pkg::MIES_OP_TMDLOAD, 8'h00, 1'b0, 8'h00);
      chk(timer0ModeReg, 8'haa);
      chk(accumulator, 8'haa);
      xr(8'h99);
      op(mies_pkg::MIES_OP_TMDREAD, 8'h00, 1'b0, 8'h00);
      chk(accumulator, 8'haa);
      chk(timer0ModeReg, 8'haa);
      ea = 8'haa;
      $display("test timer mode done");
   endtask
   task automatic t_table();
      xr(ea ^ 8'h34);
      tbl(8'h01, 14'h35aa);
      tbl(8'hfe, 14'h0c5f);
      $display("test table done");
   endtask
   // hang guard: the whole run is far shorter than this
   initial begin
      #100000;
      error_cnt++;
      end_of_test();
   end
   initial begin
      error_cnt = 0;
      cmp_count = 0;
      ea = 8'h00;
      rst = 1'b1;
      {opValid, destFile, immediate, fileData, tablePointerHigh, romData} = '0;
      opCode = mies_pkg::MIES_OP_NONE;
      repeat (12) @(negedge clk_sys);
      t_reset();
      rst = 1'b0;
      @(negedge clk_sys);
      t_sub();
      t_xor();
      t_tmd();
      t_table();
      rst = 1'b1; // second reset in mid-run
      @(negedge clk_sys);
      rst = 1'b0;
      t_reset();
      end_of_test();
   end
endmodule
